// File: core/hash_defines.svh
`ifndef HASH_DEFINES_SVH
`define HASH_DEFINES_SVH

// register byte offsets
`define HASH_CTRL_OFF      8'h00
`define HASH_STATUS_OFF    8'h04
`define HASH_INPUT_OFF     8'h08
`define HASH_MADDR_OFF     8'h0C
`define HASH_MCTRL_OFF     8'h10
`define HASH_DIGEST_SEL    3'h1

// field positions
`define HASH_CTRL_MODE     0
`define HASH_CTRL_INIT     1
`define HASH_ST_READY      0
`define HASH_ST_BUSY       1
`define HASH_ST_MACTIVE    2
`define HASH_ST_OVERRUN    3
`define HASH_MC_EN         0
`define HASH_MC_CNT_LSB    16
`define HASH_MC_CNT_MSB    27

// sizes and counts
`define HASH_MAX_BYTES     131072
`define HASH_BLOCK_BYTES   64
`define HASH_MAX_BLOCKS    (`HASH_MAX_BYTES / `HASH_BLOCK_BYTES)
`define HASH_SHA1_LAST     7'd79
`define HASH_SHA256_LAST   7'd63
`define HASH_RESET_MODE    1'b1

// round constants
`define HASH_K1_0          32'h5A827999
`define HASH_K1_1          32'h6ED9EBA1
`define HASH_K1_2          32'h8F1BBCDC
`define HASH_K1_3          32'hCA62C1D6
`define HASH_K256 { \
   64'h428A2F98_71374491, 64'hB5C0FBCF_E9B5DBA5, 64'h3956C25B_59F111F1, 64'h923F82A4_AB1C5ED5, \
   64'hD807AA98_12835B01, 64'h243185BE_550C7DC3, 64'h72BE5D74_80DEB1FE, 64'h9BDC06A7_C19BF174, \
   64'hE49B69C1_EFBE4786, 64'h0FC19DC6_240CA1CC, 64'h2DE92C6F_4A7484AA, 64'h5CB0A9DC_76F988DA, \
   64'h983E5152_A831C66D, 64'hB00327C8_BF597FC7, 64'hC6E00BF3_D5A79147, 64'h06CA6351_14292967, \
   64'h27B70A85_2E1B2138, 64'h4D2C6DFC_53380D13, 64'h650A7354_766A0ABB, 64'h81C2C92E_92722C85, \
   64'hA2BFE8A1_A81A664B, 64'hC24B8B70_C76C51A3, 64'hD192E819_D6990624, 64'hF40E3585_106AA070, \
   64'h19A4C116_1E376C08, 64'h2748774C_34B0BCB5, 64'h391C0CB3_4ED8AA4A, 64'h5B9CCA4F_682E6FF3, \
   64'h748F82EE_78A5636F, 64'h84C87814_8CC70208, 64'h90BEFFFA_A4506CEB, 64'hBEF9A3F7_C67178F2}

// initial chaining values, word 0 in the low bits
`define HASH_H1_INIT { 32'h0, 32'h0, 32'h0, 32'hC3D2E1F0, \
   32'h10325476, 32'h98BADCFE, 32'hEFCDAB89, 32'h67452301}
`define HASH_H256_INIT { 32'h5BE0CD19, 32'h1F83D9AB, 32'h9B05688C, 32'h510E527F, \
   32'hA54FF53A, 32'h3C6EF372, 32'hBB67AE85, 32'h6A09E667}

`endif

// File: core/hash_pkg.sv
package hash_pkg;

   // engine sequencing states, one-hot
   typedef enum logic [2:0] {
      fsm_idle  = 3'b001,
      fsm_round = 3'b010,
      fsm_final = 3'b100
   } hash_fsm_type;

   // complete state of the engine
   typedef struct packed {
      hash_fsm_type      state;
      logic              mode;          // 1: sha-256, 0: sha-1
      logic              digest_ready;
      logic              overrun;
      logic [3:0]        port_cnt;      // words of the current port block
      logic [6:0]        rnd;
      logic [7:0][31:0]  h;
      logic [7:0][31:0]  v;
      logic [15:0][31:0] w;             // w[15] newest schedule word
      logic              m_active;
      logic [31:0]       m_addr;
      logic [15:0]       m_left;        // words still to fetch
      logic [31:0]       rdata;
   } engine_state_type;

   function automatic logic [31:0] rotr(input logic [31:0] x, input int unsigned n);
      return (x >> n) | (x << (32 - n));
   endfunction : rotr

   function automatic logic [31:0] ch(input logic [31:0] x, y, z);
      return (x & y) | (~x & z);
   endfunction : ch

   function automatic logic [31:0] maj(input logic [31:0] x, y, z);
      return (x & y) | (x & z) | (y & z);
   endfunction : maj

endpackage : hash_pkg

// File: core/word_stream_if.sv
`timescale 1ns/1ns
interface word_stream_if #(
   parameter int WIDTH = 32
) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : word_stream_if

// File: core/word_fifo.sv
`timescale 1ns/1ns
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic    core_clk_i,
   input  wire logic    reset_i,
   // filling and draining sides
   word_stream_if.sink   in_s,
   word_stream_if.source out_s
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } fifo_state_type;

   fifo_state_type   st_r;
   fifo_state_type   st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // flags, handshakes and pointer update; depth must be a power of two
   always_comb begin
      in_s.ready   = st_r.cnt != (AW+1)'(DEPTH);
      out_s.valid  = st_r.cnt != '0;
      out_s.data   = mem[st_r.rd];
      push         = in_s.valid & in_s.ready;
      pop          = out_s.valid & out_s.ready;
      st_nxt       = st_r;
      if (push) begin
         st_nxt.wr = st_r.wr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd = st_r.rd + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // pointer state
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // storage, written only on an accepted push
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[st_r.wr] <= in_s.data;
      end
   end

   fifo_count_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      push && !pop |=> st_r.cnt == $past(st_r.cnt) + 1'b1)
      else $error("fifo count did not follow a push");
endmodule : word_fifo

// File: core/hash_engine_bus_mastering.sv
// Notes on behaviour
// - computes sha-1 or sha-256 digests over words from flash or ram
// - own bus master fetches memory blocks into the hash without the processor
// - one mastered run covers at most 128 K bytes of memory
// - first port word of a further block clears the digest-ready flag unless it arrives in the final-add cycle, where the set wins
// - a follow-on mastered run after digest ready clears the flag
`timescale 1ns/1ns
`include "hash_defines.svh"
module hash_engine_bus_mastering #(
   parameter int FIFO_DEPTH = 32
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // bus master read port
   output logic             mem_req_o,
   output logic      [31:0] mem_addr_o,
   input  wire logic        mem_ack_i,
   input  wire logic [31:0] mem_rdata_i,
   // status
   output logic             digest_ready_o
);
   localparam logic [2047:0] K256_TAB  = `HASH_K256;
   localparam logic [11:0]   MAX_BLKS  = 12'(`HASH_MAX_BLOCKS);
   localparam logic [15:0]   MAX_WORDS = 16'(`HASH_MAX_BLOCKS * 16);

   hash_pkg::engine_state_type st_r;
   hash_pkg::engine_state_type st_nxt;

   word_stream_if #(.WIDTH(32)) push_s ();
   word_stream_if #(.WIDTH(32)) pop_s ();

   logic        wr_ctrl;
   logic        wr_in;
   logic        wr_maddr;
   logic        wr_mctl;
   logic        port_take;
   logic        mem_take;
   logic        adv;
   logic        last_rnd;
   logic [11:0] blks;
   logic [31:0] wt;
   logic [31:0] kt;
   logic [31:0] t1;
   logic [31:0] t2;
   logic [31:0] f1;

   // word buffer between the two sources and the round logic
   word_fifo #(
      .WIDTH (32),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .in_s       (push_s),
      .out_s      (pop_s)
   );

   // register write decode
   always_comb begin
      wr_ctrl  = 1'b0;
      wr_in    = 1'b0;
      wr_maddr = 1'b0;
      wr_mctl  = 1'b0;
      if (reg_wr_i && reg_addr_i == `HASH_CTRL_OFF) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr_i && reg_addr_i == `HASH_INPUT_OFF) begin
         wr_in = 1'b1;
      end else if (reg_wr_i && reg_addr_i == `HASH_MADDR_OFF) begin
         wr_maddr = 1'b1;
      end else if (reg_wr_i && reg_addr_i == `HASH_MCTRL_OFF) begin
         wr_mctl = 1'b1;
      end
   end

   // source select: the master owns the buffer while a run is active
   always_comb begin
      mem_req_o    = st_r.m_active && st_r.m_left != '0 && push_s.ready;
      mem_take     = mem_req_o & mem_ack_i;
      port_take    = wr_in & ~st_r.m_active & push_s.ready;
      push_s.valid = mem_take | port_take;
      push_s.data  = st_r.m_active ? mem_rdata_i : reg_wdata_i;
      pop_s.ready  = st_r.state == hash_pkg::fsm_round && st_r.rnd < 7'd16;
      mem_addr_o     = st_r.m_addr;
      reg_rdata_o    = st_r.rdata;
      digest_ready_o = st_r.digest_ready;
      blks = reg_wdata_i[`HASH_MC_CNT_MSB:`HASH_MC_CNT_LSB];
      if (blks > MAX_BLKS) begin
         blks = MAX_BLKS;
      end
   end

   // schedule word, round constant and compression terms
   always_comb begin
      if (st_r.rnd < 7'd16) begin
         wt = pop_s.data;
      end else if (st_r.mode) begin
         wt = (hash_pkg::rotr(st_r.w[14], 17) ^ hash_pkg::rotr(st_r.w[14], 19)
               ^ (st_r.w[14] >> 10)) + st_r.w[9] + st_r.w[0]
            + (hash_pkg::rotr(st_r.w[1], 7) ^ hash_pkg::rotr(st_r.w[1], 18)
               ^ (st_r.w[1] >> 3));
      end else begin
         wt = hash_pkg::rotr(st_r.w[13] ^ st_r.w[8] ^ st_r.w[2] ^ st_r.w[0], 31);
      end
      if (st_r.rnd < 7'd20) begin
         kt = `HASH_K1_0;
         f1 = hash_pkg::ch(st_r.v[1], st_r.v[2], st_r.v[3]);
      end else if (st_r.rnd < 7'd40) begin
         kt = `HASH_K1_1;
         f1 = st_r.v[1] ^ st_r.v[2] ^ st_r.v[3];
      end else if (st_r.rnd < 7'd60) begin
         kt = `HASH_K1_2;
         f1 = hash_pkg::maj(st_r.v[1], st_r.v[2], st_r.v[3]);
      end else begin
         kt = `HASH_K1_3;
         f1 = st_r.v[1] ^ st_r.v[2] ^ st_r.v[3];
      end
      if (st_r.mode) begin
         kt = K256_TAB[(63 - int'(st_r.rnd[5:0])) * 32 +: 32];
         t1 = st_r.v[7] + kt + wt + hash_pkg::ch(st_r.v[4], st_r.v[5], st_r.v[6])
            + (hash_pkg::rotr(st_r.v[4], 6) ^ hash_pkg::rotr(st_r.v[4], 11)
               ^ hash_pkg::rotr(st_r.v[4], 25));
         t2 = hash_pkg::maj(st_r.v[0], st_r.v[1], st_r.v[2])
            + (hash_pkg::rotr(st_r.v[0], 2) ^ hash_pkg::rotr(st_r.v[0], 13)
               ^ hash_pkg::rotr(st_r.v[0], 22));
      end else begin
         t1 = hash_pkg::rotr(st_r.v[0], 27) + f1 + st_r.v[4] + kt + wt;
         t2 = '0;
      end
      last_rnd = st_r.rnd == (st_r.mode ? `HASH_SHA256_LAST : `HASH_SHA1_LAST);
      adv      = st_r.state == hash_pkg::fsm_round && (st_r.rnd >= 7'd16 || pop_s.valid);
   end

   // next state: register writes and flag clears first, then engine and flag set
   always_comb begin
      st_nxt       = st_r;
      st_nxt.rdata = '0;
      if (wr_ctrl && reg_wdata_i[`HASH_CTRL_INIT]) begin
         st_nxt.mode         = reg_wdata_i[`HASH_CTRL_MODE];
         st_nxt.h            = reg_wdata_i[`HASH_CTRL_MODE] ? `HASH_H256_INIT : `HASH_H1_INIT;
         st_nxt.digest_ready = 1'b0;
         st_nxt.overrun      = 1'b0;
         st_nxt.port_cnt     = '0;
      end
      if (port_take) begin
         st_nxt.port_cnt = st_r.port_cnt + 1'b1;
         if (st_r.port_cnt == '0) begin
            st_nxt.digest_ready = 1'b0;
         end
      end
      if (wr_maddr && !st_r.m_active) begin
         st_nxt.m_addr = reg_wdata_i;
      end
      if (wr_mctl && reg_wdata_i[`HASH_MC_EN] && !st_r.m_active) begin
         st_nxt.m_active     = blks != '0;
         st_nxt.m_left       = {blks, 4'h0};
         st_nxt.digest_ready = 1'b0;
      end
      if (mem_take) begin
         st_nxt.m_addr = st_r.m_addr + 32'h4;
         st_nxt.m_left = st_r.m_left - 16'h1;
         if (st_r.m_left == 16'h1) begin
            st_nxt.m_active = 1'b0;
         end
      end
      if (wr_in && !port_take) begin
         st_nxt.overrun = 1'b1;
      end
      case (st_r.state)
         hash_pkg::fsm_idle: begin
            if (pop_s.valid) begin
               st_nxt.v     = st_r.h;
               st_nxt.rnd   = '0;
               st_nxt.state = hash_pkg::fsm_round;
            end
         end
         hash_pkg::fsm_round: begin
            if (adv) begin
               st_nxt.w   = {wt, st_r.w[15:1]};
               st_nxt.rnd = st_r.rnd + 1'b1;
               if (st_r.mode) begin
                  st_nxt.v = {st_r.v[6:4], st_r.v[3] + t1, st_r.v[2:0], t1 + t2};
               end else begin
                  st_nxt.v = {st_r.v[7:5], st_r.v[3], st_r.v[2],
                              hash_pkg::rotr(st_r.v[1], 2), st_r.v[0], t1};
               end
               if (last_rnd) begin
                  st_nxt.state = hash_pkg::fsm_final;
               end
            end
         end
         hash_pkg::fsm_final: begin
            for (int i = 0; i < 8; i++) begin
               st_nxt.h[i] = st_r.h[i] + st_r.v[i];
            end
            st_nxt.state = hash_pkg::fsm_idle;
            if (!pop_s.valid && !st_r.m_active) begin
               st_nxt.digest_ready = 1'b1;
            end
         end
         default: begin
            st_nxt.state = hash_pkg::fsm_idle;
         end
      endcase
      // read data, valid only in the cycle after the strobe
      if (reg_rd_i && reg_addr_i == `HASH_CTRL_OFF) begin
         st_nxt.rdata[`HASH_CTRL_MODE] = st_r.mode;
      end else if (reg_rd_i && reg_addr_i == `HASH_STATUS_OFF) begin
         st_nxt.rdata[`HASH_ST_READY]   = st_r.digest_ready;
         st_nxt.rdata[`HASH_ST_BUSY]    = st_r.state != hash_pkg::fsm_idle;
         st_nxt.rdata[`HASH_ST_MACTIVE] = st_r.m_active;
         st_nxt.rdata[`HASH_ST_OVERRUN] = st_r.overrun;
      end else if (reg_rd_i && reg_addr_i == `HASH_MADDR_OFF) begin
         st_nxt.rdata = st_r.m_addr;
      end else if (reg_rd_i && reg_addr_i == `HASH_MCTRL_OFF) begin
         st_nxt.rdata[`HASH_MC_EN] = st_r.m_active;
         st_nxt.rdata[`HASH_MC_CNT_MSB:`HASH_MC_CNT_LSB] = st_r.m_left[15:4];
      end else if (reg_rd_i && reg_addr_i[7:5] == `HASH_DIGEST_SEL) begin
         st_nxt.rdata = st_r.h[reg_addr_i[4:2]];
      end
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_r       <= '0;
         st_r.state <= hash_pkg::fsm_idle;
         st_r.mode  <= `HASH_RESET_MODE;
         st_r.h     <= `HASH_H256_INIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   round_finish_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      adv && last_rnd |=> st_r.state == hash_pkg::fsm_final ##1 st_r.state == hash_pkg::fsm_idle)
      else $error("round sequence did not end in a final add");

   master_step_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      mem_take && !wr_maddr |=> mem_addr_o == $past(mem_addr_o) + 32'h4)
      else $error("master address did not step by one word");

   master_stop_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      mem_take && st_r.m_left == 16'h1 |=> !st_r.m_active && !mem_req_o)
      else $error("master kept running after its last word");

   run_length_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      st_r.m_left <= MAX_WORDS)
      else $error("mastered run longer than the limit");

   port_clear_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      port_take && st_r.port_cnt == '0 && st_r.state != hash_pkg::fsm_final
      |=> !digest_ready_o)
      else $error("first port word did not clear digest ready");

   chain_clear_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      wr_mctl && reg_wdata_i[`HASH_MC_EN] && !st_r.m_active
      && st_r.state != hash_pkg::fsm_final |=> !digest_ready_o)
      else $error("master start did not clear digest ready");

   ready_set_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      st_r.state == hash_pkg::fsm_final && !pop_s.valid && !st_r.m_active
      |=> digest_ready_o)
      else $error("digest ready not set after last block");

   ready_hold_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      digest_ready_o && !wr_ctrl && !wr_mctl && !port_take |=> digest_ready_o)
      else $error("digest ready dropped without a new block");
endmodule : hash_engine_bus_mastering

// File: bench/mem_model.sv
`timescale 1ns/1ns
// memory on the far side of the engine's bus master
module mem_model (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   // read link from the engine
   input  wire logic        mem_req_i,
   input  wire logic [31:0] mem_addr_i,
   output logic             mem_ack_o,
   output logic      [31:0] mem_rdata_o,
   // wait control and observation
   input  wire logic [3:0]  delay_i,
   output logic      [15:0] words_o,
   output logic             hold_err_o
);
   logic [3:0]  wait_r;
   logic [31:0] addr_r;

   // padded three-byte message at 0x1000, address-derived filler elsewhere
   function automatic logic [31:0] word_at(input logic [31:0] a);
      if (a == 32'h0000_1000) return 32'h6162_6380;
      if (a == 32'h0000_103C) return 32'h0000_0018;
      if (a[31:6] == 26'h40) return 32'h0;
      return a ^ 32'hA5A5_0000;
   endfunction : word_at

   // one read outstanding; the data line toggles whenever it carries no word
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= 32'h0;
         wait_r      <= 4'h0;
         words_o     <= 16'h0;
         hold_err_o  <= 1'b0;
      end else if (mem_ack_o) begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         wait_r      <= 4'h0;
         words_o     <= words_o + 16'h1;
         if (!mem_req_i || mem_addr_i !== addr_r) hold_err_o <= 1'b1;
      end else if (mem_req_i && wait_r >= delay_i) begin
         mem_ack_o   <= 1'b1;
         mem_rdata_o <= word_at(mem_addr_i);
         addr_r      <= mem_addr_i;
      end else begin
         if (mem_req_i) wait_r <= wait_r + 4'h1;
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule : mem_model

// File: bench/testbench.sv
`timescale 1ns/1ns
`define CHECK(name, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("mismatch %s expected %h seen %h", name, exp, got); \
      end \
   end
module testbench;
   logic        core_clk_i;
   logic        reset_i;
   logic [7:0]  reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [31:0] reg_rdata_o;
   logic        mem_req_o;
   logic [31:0] mem_addr_o;
   logic        mem_ack_i;
   logic [31:0] mem_rdata_i;
   logic        digest_ready_o;
   logic [3:0]  mem_delay;
   logic [15:0] words;
   logic        hold_err;
   logic [31:0] rd;
   logic [15:0] base;
   int          failures;
   int          tests_run;
   int          cycles;
   localparam logic [31:0] SHA256_ABC [8] = '{32'hBA78_16BF, 32'h8F01_CFEA, 32'h4141_40DE,
      32'h5DAE_2223, 32'hB003_61A3, 32'h9617_7A9C, 32'hB410_FF61, 32'hF200_15AD};
   localparam logic [31:0] SHA1_ABC [8] = '{32'hA999_3E36, 32'h4706_816A, 32'hBA3E_2571,
      32'h7850_C26C, 32'h9CD0_D89D, 32'h0, 32'h0, 32'h0};

   hash_engine_bus_mastering #(.FIFO_DEPTH(32)) hash_engine_bus_mastering_inst (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .digest_ready_o(digest_ready_o));

   mem_model mem_model_inst (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .mem_req_i(mem_req_o),
      .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i),
      .delay_i(mem_delay), .words_o(words), .hold_err_o(hold_err));

   // clock
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end

   // closing report
   task automatic results();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   // hang guard
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("mismatch timeout expected %h seen %h", 1'b0, 1'b1);
         results();
      end
   end

   // register port cycles, one idle cycle after each strobe
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
      @(posedge core_clk_i);
   endtask : reg_rd

   // final padded block of the three-byte message through the input port
   task automatic push_abc();
      for (int i = 0; i < 16; i++) begin
         reg_wr(8'h08, (i == 0) ? 32'h6162_6380 : (i == 15) ? 32'h0000_0018 : 32'h0);
      end
   endtask : push_abc

   task automatic wait_ready();
      int n;
      n = 0;
      while (digest_ready_o !== 1'b1 && n < 4000) begin
         @(posedge core_clk_i);
         n++;
      end
      `CHECK("digest ready", 1'b1, digest_ready_o)
   endtask : wait_ready

   task automatic chk_digest(input logic [31:0] exp [8]);
      logic [31:0] d;
      for (int i = 0; i < 8; i++) begin
         reg_rd(8'h20 + 8'(4 * i), d);
         `CHECK("digest word", exp[i], d)
      end
   endtask : chk_digest

   // main sequence
   initial begin
      reset_i     = 1'b1;
      reg_addr_i  = 8'h0;
      reg_wdata_i = 32'h0;
      reg_wr_i    = 1'b0;
      reg_rd_i    = 1'b0;
      mem_delay   = 4'h0;
      repeat (5) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      `CHECK("ready after reset", 1'b0, digest_ready_o)
      reg_rd(8'h00, rd);
      `CHECK("mode after reset", 32'h1, rd)
      reg_rd(8'h40, rd);
      `CHECK("unmapped read", 32'h0, rd)
      // sha-256 over one port block
      reg_wr(8'h00, 32'h3);
      push_abc();
      wait_ready();
      chk_digest(SHA256_ABC);
      // first word of a further block drops the flag
      reg_wr(8'h08, 32'h0);
      `CHECK("ready after port word", 1'b0, digest_ready_o)
      for (int i = 1; i < 16; i++) reg_wr(8'h08, 32'(i));
      wait_ready();
      // sha-1 via the bus master with a slow memory
      reg_wr(8'h00, 32'h2);
      mem_delay <= 4'h3;
      base = words;
      reg_wr(8'h0C, 32'h0000_1000);
      reg_wr(8'h10, 32'h0001_0001);
      wait_ready();
      `CHECK("fetched words", base + 16'd16, words)
      reg_rd(8'h0C, rd);
      `CHECK("master address", 32'h0000_1040, rd)
      chk_digest(SHA1_ABC);
      // follow-on mastered run after ready, prompt memory
      mem_delay <= 4'h0;
      base = words;
      reg_wr(8'h0C, 32'h0000_2000);
      reg_wr(8'h10, 32'h0001_0001);
      `CHECK("ready after follow-on", 1'b0, digest_ready_o)
      wait_ready();
      `CHECK("follow-on words", base + 16'd16, words)
      // chained hash: port block, then master control inside the window
      reg_wr(8'h00, 32'h3);
      base = words;
      push_abc();
      reg_wr(8'h0C, 32'h0000_1000);
      reg_wr(8'h10, 32'h0002_0001);
      `CHECK("ready after chaining", 1'b0, digest_ready_o)
      // the port block finishes about 50 cycles after its last word; flag must stay low
      repeat (50) @(posedge core_clk_i);
      `CHECK("ready past first block", 1'b0, digest_ready_o)
      wait_ready();
      `CHECK("chained words", base + 16'd32, words)
      // an empty run still drops the flag and leaves the master idle
      reg_wr(8'h10, 32'h0000_0001);
      reg_rd(8'h04, rd);
      `CHECK("empty run status", 32'h0, rd & 32'h5)
      // oversize run is clamped; port writes while mastering are refused
      mem_delay <= 4'hF;
      reg_wr(8'h0C, 32'h0000_3000);
      reg_wr(8'h10, 32'h0FFF_0001);
      reg_rd(8'h10, rd);
      `CHECK("clamped blocks", 32'h0800_0001, rd & 32'h0FFF_0001)
      reg_wr(8'h08, 32'h0);
      reg_rd(8'h04, rd);
      `CHECK("active and overrun", 32'hC, rd & 32'hC)
      `CHECK("address held", 1'b0, hold_err)
      // reset in mid-run
      reset_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      `CHECK("request after reset", 1'b0, mem_req_o)
      reg_rd(8'h04, rd);
      `CHECK("status after reset", 32'h0, rd)
      results();
   end
endmodule : testbench
